/* File: phy_status_pkg.sv */
// constants for the upper half of the phy status summary register
package phy_status_pkg;
	localparam logic [4:0] STATUS_SUMMARY_ADDR = 5'h10;
	localparam logic [4:0] FALSE_CARRIER_ADDR = 5'h14;
	localparam logic [4:0] RX_ERROR_ADDR = 5'h15;
	localparam logic [4:0] TEN_BASE_T_STATUS_ADDR = 5'h1A;
	localparam logic [4:0] AUTONEG_EXPANSION_ADDR = 5'h06;
	localparam logic [4:0] BASIC_STATUS_ADDR = 5'h01;
	localparam int CROSSOVER_BIT = 14;
	localparam int RX_ERROR_BIT = 13;
	localparam int POLARITY_BIT = 12;
	localparam int FALSE_CARRIER_BIT = 11;
	localparam int SIGNAL_DETECT_BIT = 10;
	localparam int DESCRAMBLER_LOCK_BIT = 9;
	localparam int PAGE_RECEIVED_BIT = 8;
	localparam int REMOTE_FAULT_BIT = 6;
	localparam logic [9:0] UPPER_RESET = 10'h000;
endpackage : phy_status_pkg

/* File: latch_flag.sv */
// one status flag that either latches high or latches low
`timescale 1ns/1ps
module latch_flag #(
	parameter bit LATCH_LOW = 1'b0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// source and clear
	input wire logic source,
	input wire logic clearRead,
	// held value
	output logic flag
);
	logic hold;
	logic next_flag;

	// latch-high: a new event in the clearing cycle wins over the clear
	// latch-low: holds zero until a read returns it, then tracks again
	assign hold = LATCH_LOW ? (flag & source) : (flag | source);
	assign next_flag = clearRead ? source : hold;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			flag <= 1'b0;
		else
			flag <= next_flag;
	end
endmodule : latch_flag

/* File: phy_status_summary.sv */
// upper half of the phy status summary register with its flag latches
`timescale 1ns/1ps
// How it works
// - summary register at 0x10, zero after reset
// - bits 15 and 7 always read zero
// - bit 14 shows crossover swap state
// - crossover bit follows enable, force, algorithm
// - bit 13 latches rx error, cleared by 0x15
// - bit 12 mirrors polarity, summary read keeps it
// - bit 11 latches false carrier, cleared by 0x14
// - bit 10 latch-low signal detect
// - bit 9 latch-low descrambler lock
// - bit 8 mirrors page received flag
// - bit 6 remote fault, cleared by 0x01 read
module phy_status_summary (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// management read port
	input wire logic regRead,
	input wire logic [4:0] regAddr,
	output logic [15:0] readData,
	// crossover control and state
	input wire logic auto_crossover_enable,
	input wire logic force_crossover,
	input wire logic autoSwapped,
	// live sources from the pmd and autonegotiation
	input wire logic rxErrorEvent,
	input wire logic falseCarrierEvent,
	input wire logic polarityInverted,
	input wire logic signalDetect,
	input wire logic descramblerLock,
	input wire logic pageReceived,
	input wire logic remoteFaultEvent
);
	import phy_status_pkg::*;

	function automatic logic isRead(input logic rd, input logic [4:0] a, input logic [4:0] t);
		return rd && (a == t);
	endfunction : isRead

	// ----------------------------------------
	// synchronised pin-side sources
	// ----------------------------------------
	// bit 7 swap state, 6 rx error, 5 false carrier, 4 polarity,
	// 3 signal detect, 2 lock, 1 page received, 0 remote fault
	logic [7:0] syncA;
	logic [7:0] syncB;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA <= 8'h00;
			syncB <= 8'h00;
		end
		else
		begin
			syncA <= {autoSwapped, rxErrorEvent, falseCarrierEvent, polarityInverted,
				signalDetect, descramblerLock, pageReceived, remoteFaultEvent};
			syncB <= syncA;
		end
	end

	// crossover controls get their own pair of stages
	logic [1:0] ctlSyncA;
	logic [1:0] ctlSyncB;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctlSyncA <= 2'h0;
			ctlSyncB <= 2'h0;
		end
		else
		begin
			ctlSyncA <= {auto_crossover_enable, force_crossover};
			ctlSyncB <= ctlSyncA;
		end
	end

	// ----------------------------------------
	// live mirrors
	// ----------------------------------------
	// forcing wins; with crossover off the pairs stay normal
	// controls and swap state cross separately, so a change may mix for a cycle
	logic crossoverState;
	logic polarityState;
	logic pageState;
	assign crossoverState = ctlSyncB[0] | (ctlSyncB[1] & syncB[7]);
	// mirrors only: no register read clears them, a summary read included
	assign polarityState = syncB[4];
	assign pageState = syncB[1];

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	// other addresses are decoded only for their clearing side effects
	logic readSummary;
	logic readRxErr;
	logic readFalseCarrier;
	logic readBasic;
	assign readSummary = isRead(regRead, regAddr, STATUS_SUMMARY_ADDR);
	assign readRxErr = isRead(regRead, regAddr, RX_ERROR_ADDR);
	assign readFalseCarrier = isRead(regRead, regAddr, FALSE_CARRIER_ADDR);
	assign readBasic = isRead(regRead, regAddr, BASIC_STATUS_ADDR);

	// ----------------------------------------
	// flags
	// ----------------------------------------
	logic rxErrFlag;
	logic falseCarrierFlag;
	logic signalFlag;
	logic lockFlag;
	logic faultFlag;

	latch_flag #(.LATCH_LOW(1'b0)) u_rxerr (.clk_sys(clk_sys), .rst_n(rst_n),
		.source(syncB[6]), .clearRead(readRxErr), .flag(rxErrFlag));
	latch_flag #(.LATCH_LOW(1'b0)) u_fcs (.clk_sys(clk_sys), .rst_n(rst_n),
		.source(syncB[5]), .clearRead(readFalseCarrier), .flag(falseCarrierFlag));
	// latch-low bits rearm only after the summary read returned them
	latch_flag #(.LATCH_LOW(1'b1)) u_sd (.clk_sys(clk_sys), .rst_n(rst_n),
		.source(syncB[3]), .clearRead(readSummary), .flag(signalFlag));
	latch_flag #(.LATCH_LOW(1'b1)) u_lock (.clk_sys(clk_sys), .rst_n(rst_n),
		.source(syncB[2]), .clearRead(readSummary), .flag(lockFlag));
	latch_flag #(.LATCH_LOW(1'b0)) u_rf (.clk_sys(clk_sys), .rst_n(rst_n),
		.source(syncB[0]), .clearRead(readBasic), .flag(faultFlag));

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [15:0] summary;
	always_comb
	begin
		summary = 16'h0000;
		summary[CROSSOVER_BIT] = crossoverState;
		summary[RX_ERROR_BIT] = rxErrFlag;
		summary[POLARITY_BIT] = polarityState;
		summary[FALSE_CARRIER_BIT] = falseCarrierFlag;
		summary[SIGNAL_DETECT_BIT] = signalFlag;
		summary[DESCRAMBLER_LOCK_BIT] = lockFlag;
		summary[PAGE_RECEIVED_BIT] = pageState;
		summary[REMOTE_FAULT_BIT] = faultFlag;
	end

	// lower six bits belong to another block and read zero here
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			readData <= {UPPER_RESET, 6'h00};
		else if (readSummary)
			readData <= summary;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// register image
	reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readData[15] == 1'b0 && readData[7] == 1'b0) else $error("reserved bit set");
	low_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readData[5:0] == 6'h00) else $error("lower bits not zero");
	read_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!readSummary |=> $stable(readData)) else $error("read data moved");

	// latched-high flags: an event in the clearing cycle wins
	rxerr_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		syncB[6] |=> rxErrFlag) else $error("rx error not latched");
	rxerr_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rxErrFlag && !readRxErr |=> rxErrFlag) else $error("rx error flag lost");
	rxerr_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readRxErr && !syncB[6] |=> !rxErrFlag) else $error("rx error not cleared");
	fcs_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		syncB[5] |=> falseCarrierFlag) else $error("false carrier not latched");
	fcs_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		falseCarrierFlag && !readFalseCarrier |=> falseCarrierFlag)
		else $error("false carrier lost");
	fcs_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readFalseCarrier && !syncB[5] |=> !falseCarrierFlag) else $error("carrier not cleared");
	fault_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		syncB[0] |=> faultFlag) else $error("fault not latched");
	fault_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		faultFlag && !readBasic |=> faultFlag) else $error("fault lost");
	fault_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readBasic && !syncB[0] |=> !faultFlag) else $error("fault not cleared");

	// mirrors: a summary read returns the live level
	pol_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readSummary |=> readData[POLARITY_BIT] == $past(syncB[4]))
		else $error("polarity read wrong");
	page_mirror_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readSummary |=> readData[PAGE_RECEIVED_BIT] == $past(syncB[1]))
		else $error("page received read wrong");
	read_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readSummary |=> readData[CROSSOVER_BIT] == $past(crossoverState))
		else $error("crossover read wrong");
	cross_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctlSyncB[0] |-> crossoverState) else $error("forced crossover not shown");
	cross_auto_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctlSyncB[1] && !ctlSyncB[0] |-> crossoverState == syncB[7])
		else $error("crossover not following swap");

	// latch-low bits: zero holds until a summary read returns it
	sd_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!syncB[3] |=> !signalFlag) else $error("signal drop missed");
	lock_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!syncB[2] |=> !lockFlag) else $error("lock drop missed");
	sd_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!signalFlag && !readSummary |=> !signalFlag) else $error("signal rearmed early");
	lock_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!lockFlag && !readSummary |=> !lockFlag) else $error("lock rearmed early");
	sd_rearm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		readSummary |=> signalFlag == $past(syncB[3]))
		else $error("signal not rearmed");

	// main scenarios
	sd_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		!signalFlag ##1 readSummary ##1 signalFlag);
	rxerr_clr_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		rxErrFlag ##1 readRxErr ##1 !rxErrFlag);
	fault_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		faultFlag ##1 readBasic);
	lock_read_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		!lockFlag ##1 readSummary ##1 lockFlag);
	cross_auto_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
		ctlSyncB[1] && !ctlSyncB[0] && syncB[7]);
endmodule : phy_status_summary

/* File: mgmt_station.sv */
// station management controller model issuing register reads
`timescale 1ns/1ps
module mgmt_station (
	// clock
	input wire logic clk_sys,
	// management read port
	output logic regRead,
	output logic [4:0] regAddr,
	input wire logic [15:0] readData
);
	initial
	begin
		regRead = 1'h0;
		regAddr = 5'h00;
	end
	// request held over the taking edge; the answer lands on that edge
	task automatic read_reg(input logic [4:0] addr, output logic [15:0] data);
		@(posedge clk_sys);
		#1 regRead = 1'h1;
		regAddr = addr;
		@(posedge clk_sys);
		#1 regRead = 1'h0;
		regAddr = ~addr;
		data = readData;
	endtask : read_reg
endmodule : mgmt_station

/* File: phy_status_summary_test.sv */
// testbench for the upper half of the phy status summary register
`timescale 1ns/1ps
module phy_status_summary_test;
	import phy_status_pkg::*;
	logic clk_sys, rst_n, regRead, autoEn, forceX, swapped, polarity, page;
	logic [4:0] regAddr;
	logic [15:0] readData, got;
	logic [2:0] ev;
	logic [1:0] live;
	logic [15:0] evBit[3] = '{16'h2000, 16'h0800, 16'h0040};
	logic [4:0] clrAddr[3] = '{RX_ERROR_ADDR, FALSE_CARRIER_ADDR, BASIC_STATUS_ADDR};
	int n_errors = 0;
	int total_checks = 0;
	phy_status_summary dut (.clk_sys(clk_sys), .rst_n(rst_n), .regRead(regRead),
		.regAddr(regAddr), .readData(readData), .auto_crossover_enable(autoEn),
		.force_crossover(forceX), .autoSwapped(swapped), .rxErrorEvent(ev[0]),
		.falseCarrierEvent(ev[1]), .polarityInverted(polarity), .signalDetect(live[0]),
		.descramblerLock(live[1]), .pageReceived(page), .remoteFaultEvent(ev[2]));
	mgmt_station station (.clk_sys(clk_sys), .regRead(regRead), .regAddr(regAddr),
		.readData(readData));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: read %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [15:0] exp);
		station.read_reg(STATUS_SUMMARY_ADDR, got);
		chk(got, exp);
	endtask : rd_chk
	// events run through a two-stage synchroniser, so allow a few edges
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out
	initial
	begin
		clk_sys = 1'h0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		close_out();
	end
	initial
	begin
		{rst_n, autoEn, forceX, swapped, polarity, page, ev, live} = 11'h003;
		idle(20);
		rst_n = 1'h1;
		idle(3);
		rd_chk(16'h0000);
		rd_chk(16'h0600);
		{forceX, polarity, page} = 3'h7;
		idle(4);
		rd_chk(16'h5700);
		rd_chk(16'h5700);
		{forceX, autoEn, swapped} = 3'h3;
		idle(4);
		rd_chk(16'h5700);
		swapped = 1'h0;
		idle(4);
		rd_chk(16'h1700);
		{autoEn, swapped, polarity, page} = 4'h4;
		idle(4);
		rd_chk(16'h0600);
		$display("mirror test done");
		for (int i = 0; i < 3; i++)
		begin
			ev[i] = 1'h1;
			idle(3);
			station.read_reg(clrAddr[i], got);
			ev[i] = 1'h0;
			idle(3);
			rd_chk(16'h0600 | evBit[i]);
			rd_chk(16'h0600 | evBit[i]);
			station.read_reg(clrAddr[i], got);
			rd_chk(16'h0600);
		end
		for (int i = 0; i < 2; i++)
		begin
			live[i] = 1'h0;
			idle(4);
			live[i] = 1'h1;
			idle(4);
			rd_chk(i ? 16'h0400 : 16'h0200);
			rd_chk(16'h0600);
		end
		station.read_reg(5'h1F, got);
		chk(got, 16'h0600);
		$display("latch test done");
		ev[2] = 1'h1;
		idle(3);
		{ev[2], rst_n} = 2'h0;
		idle(2);
		rst_n = 1'h1;
		idle(3);
		rd_chk(16'h0000);
		$display("reset test done");
		close_out();
	end
endmodule : phy_status_summary_test
